/* shared/rst_ctrl_map.svh */
// Register offsets, field positions, reset values and timing counts of the reset controller
`ifndef RST_CTRL_MAP_SVH
`define RST_CTRL_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_WDOG        8'h04
`define OFS_WDOG_TMO    8'h08
`define OFS_LVM         8'h0C
`define OFS_STATUS      8'h10
`define OFS_PWR         8'h14

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTRL_SOFT_REQ   0
`define CTRL_SOFT_BLOCK 1
`define WDOG_EN         0
`define WDOG_KICK       1
`define LVM_DTRIP_LO    0
`define LVM_ATRIP_LO    4
`define LVM_DEN         8
`define LVM_AEN         9
`define LVM_HEN         10
`define STAT_EXT        0
`define STAT_SOFT       1
`define STAT_WDOG       2
`define STAT_DLV        3
`define STAT_ALV        4
`define STAT_AHV        5
`define PWR_POR_DONE    2

// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define WDOG_TMO_RST    16'hFFFF
`define LVI_TRIP_RST    4'h0
`define LVI_TRIP_MAX    4'hC
`define STATUS_RST      6'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define MCLK_MHZ        250
`define POR_MIN_NS      100
`define POR_MIN_CYC     ((`POR_MIN_NS * `MCLK_MHZ + 999) / 1000)

`endif

/* shared/rst_ctrl_pkg.sv */
// Types shared by the reset controller and its bench
package rst_ctrl_pkg;

    // Global power state
    typedef enum logic [1:0] {
        MODE_ACTIVE = 2'b00,
        MODE_ALT    = 2'b01,
        MODE_SLEEP  = 2'b10,
        MODE_HIB    = 2'b11
    } pwr_mode_e;

    // Reset sequencer state
    typedef enum logic [1:0] {
        ST_HOLD    = 2'b00,
        ST_STRETCH = 2'b01,
        ST_RUN     = 2'b10
    } rst_state_e;

    // Supply presence flags from the analog side
    typedef struct packed {
        logic vddd_ok;
        logic vdda_ok;
        logic vddio1_ok;
    } supply_s;

    // Comparator outputs of the supply monitors
    typedef struct packed {
        logic vddd_below;
        logic vdda_below;
        logic vdda_above;
    } monitor_s;

    // Low and high voltage monitor setup
    typedef struct packed {
        logic       ahv_en;
        logic       alv_en;
        logic       dlv_en;
        logic [3:0] atrip;
        logic [3:0] dtrip;
    } lvm_cfg_s;

endpackage : rst_ctrl_pkg

/* hdl/sys_reset_ctrl.sv */
// System reset merger, watchdog, supply monitor gating and reset status
// Summary of operation
// [R1] Pin held low keeps device in reset
// [R2] Pin reset behaves like power-on reset
// [R3] Pin reset works in sleep and hibernate
// [R4] Writing software request bit starts reset
// [R5] Software reset behaves like power-on reset
// [R6] Block bit suppresses software reset requests
// [R7] Watchdog timeout without restart resets system
// [R8] Power-on leaves watchdog disabled
// [R9] Watchdog enable cleared only by power-on
// [R10] Watchdog counts only in active state
// [R11] Power-on reset lasts at least 100 ns
// [R12] Detector off when stable; oscillator after supplies
// [R13] Supply monitors off until power-on completes
// [R14] Supply monitors off in low-power states
// [R15] Status records causes; cleared by power-on
// [R16] System reset clears block and peripheral registers
// [R17] Low trip settings stepped; lowest flags detect
// [R18] High voltage trip is fixed, not programmable
// [R19] Monitors raise interrupts when enabled and tripped
// [R20] Stay in reset until three supplies present
// [R21] Sources OR together; release after all drop
// [R22] Wake (except from hibernate) or reset returns state to active
`timescale 1ns/10ps
`include "rst_ctrl_map.svh"

module sys_reset_ctrl
    import rst_ctrl_pkg::*;
#(
    parameter int STRETCH_CYC = `POR_MIN_CYC,
    parameter int WDOG_W      = 16
) (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic        ext_reset_n,
    input  wire supply_s     supplies,
    input  wire monitor_s    monitors,
    input  wire logic        periodic_wake_timewheel,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             sys_reset,
    output logic             por_det_en,
    output logic             main_osc_en,
    output pwr_mode_e        pwr_mode,
    output logic [3:0]       dlv_trip,
    output logic [3:0]       alv_trip,
    output logic             digital_low_volt_irq,
    output logic             analog_low_volt_irq,
    output logic             analog_high_volt_irq,
    output logic             low_volt_detect
);

    // ------------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------------
    // Stretch counter is 8 bits wide; timeout register fits a 32-bit word
    initial begin
        if (STRETCH_CYC < 1 || STRETCH_CYC > 255)
            $error("STRETCH_CYC must lie in 1..255");
        if (WDOG_W < 1 || WDOG_W > 32)
            $error("WDOG_W must lie in 1..32");
    end

    localparam logic [7:0] STRETCH_LAST = 8'(STRETCH_CYC - 1);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    rst_state_e         state_q;
    logic [7:0]         stretch_q;
    logic               sys_reset_q, por_done_q, por_det_en_q, main_osc_en_q;
    logic               soft_pend_q, soft_block_q, wdog_en_q;
    logic [WDOG_W-1:0]  wdog_cnt_q, wdog_tmo_q;
    lvm_cfg_s           lvm_q;
    logic [5:0]         status_q, status_set, status_clr;
    pwr_mode_e          mode_q;
    logic               dlv_irq_q, alv_irq_q, ahv_irq_q, lvd_q;
    logic [31:0]        rdata_d, rdata_q;
    logic               supplies_ok, rst_src, wr_ok, kick;
    logic               wdog_run, wdog_fire, mon_on;

    // ------------------------------------------------------------------------
    // Reset source merge
    // ------------------------------------------------------------------------
    // Pin is not gated by power state, so it still works in low-power states
    assign supplies_ok = supplies.vddd_ok & supplies.vdda_ok & supplies.vddio1_ok; // see [R20]
    assign rst_src     = ~ext_reset_n | soft_pend_q | wdog_fire | ~supplies_ok; // see [R21] [R3]
    // Writes other than status clears are ignored while the system is held in reset
    assign wr_ok       = reg_wr & ~sys_reset_q;
    assign kick        = wr_ok && reg_addr == `OFS_WDOG && reg_wdata[`WDOG_KICK];

    // ------------------------------------------------------------------------
    // Reset sequencer, power-on bookkeeping and software reset
    // ------------------------------------------------------------------------
    // Every source goes through the same hold and stretch, so all look like power-on
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q     <= ST_HOLD;
            stretch_q   <= 8'h00;
            sys_reset_q <= 1'b1;
        end else if (clk_en) begin
            case (state_q)
                ST_HOLD: begin
                    stretch_q <= 8'h00;
                    if (!rst_src)
                        state_q <= ST_STRETCH;
                end
                ST_STRETCH: begin
                    if (rst_src) begin
                        state_q <= ST_HOLD; // see [R21]
                    end else if (stretch_q == STRETCH_LAST) begin
                        state_q     <= ST_RUN; // see [R11]
                        sys_reset_q <= 1'b0;
                    end else begin
                        stretch_q <= stretch_q + 8'h01;
                    end
                end
                ST_RUN: begin
                    if (rst_src) begin
                        state_q     <= ST_HOLD; // see [R1] [R2] [R5] [R7]
                        sys_reset_q <= 1'b1;
                    end
                end
                default: begin
                    state_q     <= ST_HOLD;
                    sys_reset_q <= 1'b1;
                end
            endcase
        end
    end

    // Detector stays on until the digital supply is seen stable; saves power later
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            por_done_q    <= 1'b0;
            por_det_en_q  <= 1'b1;
            main_osc_en_q <= 1'b0;
        end else if (clk_en) begin
            if (state_q == ST_RUN)
                por_done_q <= 1'b1;
            if (supplies.vddd_ok)
                por_det_en_q <= 1'b0; // see [R12]
            if (supplies_ok)
                main_osc_en_q <= 1'b1; // see [R12]
        end
    end

    // Request is taken by the sequencer, then drops once reset is asserted
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            soft_pend_q  <= 1'b0;
            soft_block_q <= 1'b0;
        end else if (clk_en) begin
            if (sys_reset_q) begin
                soft_pend_q  <= 1'b0;
                soft_block_q <= 1'b0; // see [R16]
            end else if (wr_ok && reg_addr == `OFS_CTRL) begin
                soft_block_q <= reg_wdata[`CTRL_SOFT_BLOCK];
                if (reg_wdata[`CTRL_SOFT_REQ] && !soft_block_q)
                    soft_pend_q <= 1'b1; // see [R4] [R6]
            end
        end
    end

    // ------------------------------------------------------------------------
    // Watchdog and power state
    // ------------------------------------------------------------------------
    // Enable is sticky and survives system reset; only power-on clears it
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wdog_en_q <= 1'b0; // see [R8]
        end else if (clk_en) begin
            if (wr_ok && reg_addr == `OFS_WDOG && reg_wdata[`WDOG_EN])
                wdog_en_q <= 1'b1; // see [R9]
        end
    end

    assign wdog_run  = wdog_en_q & (mode_q == MODE_ACTIVE) & ~sys_reset_q; // see [R10]
    assign wdog_fire = wdog_run & ~kick & (wdog_cnt_q >= wdog_tmo_q); // see [R7]
    // Counter frozen outside active state, so it gives no cover in sleep
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wdog_cnt_q <= '0;
            wdog_tmo_q <= WDOG_W'(`WDOG_TMO_RST);
        end else if (clk_en) begin
            if (sys_reset_q) begin
                wdog_cnt_q <= '0;
                wdog_tmo_q <= WDOG_W'(`WDOG_TMO_RST); // see [R16]
            end else begin
                if (wr_ok && reg_addr == `OFS_WDOG_TMO)
                    wdog_tmo_q <= reg_wdata[WDOG_W-1:0];
                if (wdog_run)
                    wdog_cnt_q <= kick ? '0 : wdog_cnt_q + 1'b1; // see [R10]
            end
        end
    end

    // Hibernate is left through reset or a power register write; a timewheel wake cannot reach it
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= MODE_ACTIVE;
        end else if (clk_en) begin
            if (sys_reset_q)
                mode_q <= MODE_ACTIVE; // see [R22]
            else if (periodic_wake_timewheel && mode_q != MODE_HIB)
                mode_q <= MODE_ACTIVE; // see [R22]
            else if (wr_ok && reg_addr == `OFS_PWR)
                mode_q <= pwr_mode_e'(reg_wdata[1:0]);
        end
    end

    // ------------------------------------------------------------------------
    // Supply monitor setup and interrupts
    // ------------------------------------------------------------------------
    assign mon_on = por_done_q & (mode_q == MODE_ACTIVE || mode_q == MODE_ALT); // see [R13] [R14]
    // Out-of-range trip codes clamp to the top step rather than wrap
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            lvm_q <= '{ahv_en: 1'b0, alv_en: 1'b0, dlv_en: 1'b0,
                       atrip: `LVI_TRIP_RST, dtrip: `LVI_TRIP_RST};
        end else if (clk_en) begin
            if (sys_reset_q) begin
                lvm_q <= '{ahv_en: 1'b0, alv_en: 1'b0, dlv_en: 1'b0,
                           atrip: `LVI_TRIP_RST, dtrip: `LVI_TRIP_RST};
            end else if (wr_ok && reg_addr == `OFS_LVM) begin
                lvm_q.dtrip  <= (reg_wdata[`LVM_DTRIP_LO +: 4] > `LVI_TRIP_MAX) ?
                                `LVI_TRIP_MAX : reg_wdata[`LVM_DTRIP_LO +: 4]; // see [R17]
                lvm_q.atrip  <= (reg_wdata[`LVM_ATRIP_LO +: 4] > `LVI_TRIP_MAX) ?
                                `LVI_TRIP_MAX : reg_wdata[`LVM_ATRIP_LO +: 4]; // see [R17]
                lvm_q.dlv_en <= reg_wdata[`LVM_DEN];
                lvm_q.alv_en <= reg_wdata[`LVM_AEN];
                lvm_q.ahv_en <= reg_wdata[`LVM_HEN];
            end
        end
    end

    // High trip has no setting here: the comparator level is fixed in analog
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dlv_irq_q <= 1'b0;
            alv_irq_q <= 1'b0;
            ahv_irq_q <= 1'b0;
            lvd_q     <= 1'b0;
        end else if (clk_en) begin
            dlv_irq_q <= mon_on & lvm_q.dlv_en & monitors.vddd_below; // see [R19]
            alv_irq_q <= mon_on & lvm_q.alv_en & monitors.vdda_below; // see [R19]
            ahv_irq_q <= mon_on & lvm_q.ahv_en & monitors.vdda_above; // see [R18]
            lvd_q     <= mon_on & ((lvm_q.dtrip == 4'h0 & monitors.vddd_below) |
                                   (lvm_q.atrip == 4'h0 & monitors.vdda_below)); // see [R17]
        end
    end

    // ------------------------------------------------------------------------
    // Reset status
    // ------------------------------------------------------------------------
    // Write one to clear; a cause arriving in the clearing cycle still sticks
    assign status_set = {ahv_irq_q, alv_irq_q, dlv_irq_q, wdog_fire,
                         soft_pend_q, ~ext_reset_n};
    assign status_clr = (reg_wr && reg_addr == `OFS_STATUS) ? reg_wdata[5:0] : 6'h00;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            status_q <= `STATUS_RST; // see [R15]
        else if (clk_en)
            status_q <= (status_q & ~status_clr) | status_set; // see [R15]
    end

    // ------------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------------
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (reg_addr)
            `OFS_CTRL:     rdata_d[`CTRL_SOFT_BLOCK] = soft_block_q;
            `OFS_WDOG:     rdata_d[`WDOG_EN] = wdog_en_q;
            `OFS_WDOG_TMO: rdata_d[WDOG_W-1:0] = wdog_tmo_q;
            `OFS_LVM:      rdata_d[10:0] = lvm_q;
            `OFS_STATUS:   rdata_d[5:0] = status_q;
            `OFS_PWR: begin
                rdata_d[1:0]           = mode_q;
                rdata_d[`PWR_POR_DONE] = por_done_q;
            end
            default:       rdata_d = 32'h0000_0000;
        endcase
    end

    // Data stand only in the cycle after the strobe
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            rdata_q <= 32'h0000_0000;
        else if (clk_en)
            rdata_q <= reg_rd ? rdata_d : 32'h0000_0000;
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign reg_rdata            = rdata_q;
    assign sys_reset            = sys_reset_q; // see [R16]
    assign por_det_en           = por_det_en_q;
    assign main_osc_en          = main_osc_en_q;
    assign pwr_mode             = mode_q;
    assign dlv_trip             = lvm_q.dtrip;
    assign alv_trip             = lvm_q.atrip;
    assign digital_low_volt_irq = dlv_irq_q;
    assign analog_low_volt_irq  = alv_irq_q;
    assign analog_high_volt_irq = ahv_irq_q;
    assign low_volt_detect      = lvd_q;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    property p_ext_hold;
        clk_en && !ext_reset_n |=> sys_reset_q;
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("pin low without reset"); // see [R1]
    property p_soft_take;
        wr_ok && reg_addr == `OFS_CTRL && reg_wdata[`CTRL_SOFT_REQ] && !soft_block_q && clk_en
            |=> soft_pend_q ##1 (sys_reset_q || !$past(clk_en));
    endproperty
    a_soft_take: assert property (p_soft_take) else $error("soft request lost"); // see [R4]
    property p_soft_block;
        soft_block_q && !soft_pend_q && !sys_reset_q |=> !soft_pend_q;
    endproperty
    a_soft_block: assert property (p_soft_block) else $error("blocked request taken"); // see [R6]
    property p_wdog_sticky;
        wdog_en_q |=> wdog_en_q;
    endproperty
    a_wdog_sticky: assert property (p_wdog_sticky) else $error("watchdog enable cleared"); // see [R9]
    property p_wdog_fire;
        clk_en && wdog_fire |=> sys_reset_q && state_q == ST_HOLD;
    endproperty
    a_wdog_fire: assert property (p_wdog_fire) else $error("timeout gave no reset"); // see [R7]
    property p_wdog_idle;
        mode_q != MODE_ACTIVE && !sys_reset_q |=> $stable(wdog_cnt_q);
    endproperty
    a_wdog_idle: assert property (p_wdog_idle) else $error("watchdog ran in low power"); // see [R10]
    property p_por_min;
        $fell(sys_reset_q) |-> $past(stretch_q) == STRETCH_LAST && $past(state_q) == ST_STRETCH;
    endproperty
    a_por_min: assert property (p_por_min) else $error("reset released early"); // see [R11]
    property p_mon_off;
        clk_en && !mon_on |=> !dlv_irq_q && !alv_irq_q && !ahv_irq_q && !lvd_q;
    endproperty
    a_mon_off: assert property (p_mon_off) else $error("monitor active when off"); // see [R13]
    property p_supply;
        clk_en && !supplies_ok |=> sys_reset_q;
    endproperty
    a_supply: assert property (p_supply) else $error("left reset without supplies"); // see [R20]
    property p_wake;
        clk_en && periodic_wake_timewheel && mode_q == MODE_SLEEP |=> mode_q == MODE_ACTIVE;
    endproperty
    a_wake: assert property (p_wake) else $error("wake did not restore active"); // see [R22]

    c_soft_reset: cover property (soft_pend_q ##1 sys_reset_q);
    c_wdog_reset: cover property (wdog_fire ##1 sys_reset_q);
    c_release:    cover property ($fell(sys_reset_q));
    c_dlv_irq:    cover property ($rose(dlv_irq_q));

endmodule : sys_reset_ctrl

/* testbench/supply_partner.sv */
// Far-side model: external reset driver and on-chip supply monitors
`timescale 1ns/10ps

module supply_partner
    import rst_ctrl_pkg::*;
#(
    parameter int RAMP_CYC = 30
) (
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic       pin_low,
    input  wire logic [2:0] drop,
    input  wire logic [2:0] below,
    output logic            ext_reset_n,
    output supply_s         supplies,
    output monitor_s        monitors
);
    int ramp_q;

    // Slow supply ramp so the power-on pulse is stretched
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ramp_q <= 0;
        end else if (ramp_q < RAMP_CYC) begin
            ramp_q <= ramp_q + 1;
        end
    end

    // Weak pull-up: pin reads high unless driven low
    assign ext_reset_n = !pin_low;
    // Supplies absent until ramped; drop knocks single rails out
    assign supplies    = (ramp_q >= RAMP_CYC) ? supply_s'(~drop) : supply_s'(3'b000);
    assign monitors    = monitor_s'(below);
endmodule : supply_partner

/* testbench/test_system_reset_and_supply_monitor.sv */
// Self-checking bench for the system reset controller
`timescale 1ns/10ps
`include "rst_ctrl_map.svh"

module test_system_reset_and_supply_monitor
    import rst_ctrl_pkg::*;
;
    localparam int STR = 2;
    logic        mclk = 0, rst_b = 0, pin_low = 0, wake = 0, reg_wr = 0, reg_rd = 0, clk_en = 1;
    logic [2:0]  drop = 0, below = 0;
    logic [7:0]  reg_addr = 0;
    logic [31:0] reg_wdata = 0, rd_q, reg_rdata;
    logic [3:0]  t, dlv_trip, alv_trip;
    logic        ext_reset_n, sys_reset, por_det_en, main_osc_en, low_volt_detect;
    logic        digital_low_volt_irq, analog_low_volt_irq, analog_high_volt_irq;
    supply_s     supplies;
    monitor_s    monitors;
    pwr_mode_e   pwr_mode;
    int          n_fail = 0, checks = 0, cyc = 0, seed = 66, n = 0, tmo;

    sys_reset_ctrl #(.STRETCH_CYC(STR), .WDOG_W(16)) dut_u (.mclk, .rst_b, .clk_en,
        .ext_reset_n, .supplies, .monitors, .periodic_wake_timewheel(wake), .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sys_reset, .por_det_en, .main_osc_en,
        .pwr_mode, .dlv_trip, .alv_trip, .digital_low_volt_irq, .analog_low_volt_irq,
        .analog_high_volt_irq, .low_volt_detect);
    supply_partner far_u (.mclk, .rst_b, .pin_low, .drop, .below, .ext_reset_n, .supplies,
        .monitors);

    // Clock and a cycle ceiling so a hang still reaches the verdict
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            results();
        end
    end

    function automatic logic [3:0] clamp(input logic [3:0] v);
        return (v > `LVI_TRIP_MAX) ? `LVI_TRIP_MAX : v;
    endfunction : clamp

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        rd_q = reg_rdata;
    endtask : rd

    // Bounded wait for the reset output; n keeps the cycles spent
    task automatic wait_sr(input logic v, input int lim);
        n = 0;
        while (sys_reset !== v && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk(sys_reset, v, "sys_reset");
    endtask : wait_sr

    task automatic settle(input int c);
        repeat (c) @(posedge mclk);
        #1;
    endtask : settle

    task automatic results;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results

    initial begin
        settle(10);
        chk({sys_reset, por_det_en, main_osc_en}, 3'b110, "por");
        settle(10);
        rst_b <= 1'b1;
        settle(2);
        chk(sys_reset, 1, "ramp");
        wait_sr(0, 80);
        chk({por_det_en, main_osc_en}, 2'b01, "osc");
        rd(`OFS_STATUS);
        chk(rd_q, 0, "status");
        settle(1);
        chk(reg_rdata, 0, "rd_idle");
        rd(`OFS_WDOG);
        chk(rd_q[0], 0, "wd_en");
        rd(`OFS_PWR);
        chk(rd_q[2], 1, "por_done");
        rd(8'h3C);
        chk(rd_q, 0, "unmapped");
        // Software request, then a blocked request
        wr(`OFS_CTRL, 32'h0000_0001);
        wait_sr(1, 4);
        wait_sr(0, 40);
        chk(n >= STR, 1, "stretch");
        rd(`OFS_STATUS);
        chk(rd_q[1], 1, "st_soft");
        wr(`OFS_STATUS, 32'h0000_003F);
        wr(`OFS_CTRL, 32'h0000_0002);
        wr(`OFS_CTRL, 32'h0000_0001);
        settle(8);
        chk(sys_reset, 0, "blocked");
        // Pin reset taken in hibernate
        wr(`OFS_PWR, 32'h0000_0003);
        settle(2);
        chk(pwr_mode, MODE_HIB, "hib");
        pin_low <= 1'b1;
        wait_sr(1, 4);
        settle(20);
        chk(sys_reset, 1, "pin_hold");
        pin_low <= 1'b0;
        wait_sr(0, 40);
        chk(pwr_mode, MODE_ACTIVE, "wake_rst");
        rd(`OFS_STATUS);
        chk(rd_q[0], 1, "st_pin");
        drop <= 3'b001;
        wait_sr(1, 4);
        drop <= 3'b000;
        wait_sr(0, 40);
        // Monitor trips with random codes, then gating in sleep
        for (int i = 0; i < 3; i++) begin
            t = 4'($random(seed));
            wr(`OFS_LVM, {21'h0, 3'b111, t, 4'h0});
            rd(`OFS_LVM);
            chk(rd_q[7:4], clamp(t), "atrip");
            chk({alv_trip, dlv_trip}, {clamp(t), 4'h0}, "trips");
        end
        below <= 3'b100;
        settle(3);
        chk({digital_low_volt_irq, low_volt_detect}, 2'b11, "dlv");
        chk(analog_low_volt_irq, 0, "alv_off");
        chk(analog_high_volt_irq, 0, "ahv_off");
        below <= 3'b011;
        settle(3);
        chk({analog_low_volt_irq, analog_high_volt_irq}, 2'b11, "alv_ahv");
        chk(low_volt_detect, clamp(t) == 4'h0, "lvd_a");
        wr(`OFS_PWR, 32'h0000_0002);
        settle(3);
        chk({analog_low_volt_irq, analog_high_volt_irq}, 2'b00, "sleep_off");
        // Clock enable low freezes the wake request
        clk_en <= 1'b0;
        wake   <= 1'b1;
        settle(2);
        chk(pwr_mode, MODE_SLEEP, "frozen");
        clk_en <= 1'b1;
        settle(1);
        wake   <= 1'b0;
        settle(2);
        chk(pwr_mode, MODE_ACTIVE, "wake");
        below <= 3'b000;
        rd(`OFS_STATUS);
        chk(rd_q[5:3], 3'b111, "st_mon");
        // Watchdog: frozen in sleep, kicks hold it off, then it fires
        tmo = 8 + ($random(seed) & 15);
        wr(`OFS_WDOG_TMO, tmo);
        wr(`OFS_PWR, 32'h0000_0002);
        wr(`OFS_WDOG, 32'h0000_0001);
        settle(3 * tmo);
        chk(sys_reset, 0, "wd_sleep");
        wr(`OFS_PWR, 32'h0000_0000);
        repeat (4) wr(`OFS_WDOG, 32'h0000_0003);
        wait_sr(1, 60);
        chk(n >= tmo, 1, "wd_time");
        wait_sr(0, 40);
        rd(`OFS_STATUS);
        chk(rd_q[2], 1, "st_wd");
        wr(`OFS_WDOG, 32'h0000_0000);
        rd(`OFS_WDOG);
        chk(rd_q[0], 1, "wd_sticky");
        results();
    end
endmodule : test_system_reset_and_supply_monitor
